// >>> dkcl_pkg.sv
// Package: constants, enums and carrier structs for the keypad configuration logic
package dkcl_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [4:0] ADDR_W = 5'd5;
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_USRDEF = 5'h01;
   localparam logic [4:0] A_INIT = 5'h02;
   localparam logic [4:0] A_CAP = 5'h03;
   localparam logic [4:0] A_ELAPSED = 5'h04;
   localparam logic [4:0] A_FAN = 5'h05;
   localparam logic [4:0] A_CLEAR = 5'h06;
   localparam logic [4:0] A_STATUS = 5'h07;
   localparam logic [4:0] A_SPEED = 5'h08;
   localparam logic [4:0] A_PEND = 5'h09;
   localparam logic [4:0] A_STORED = 5'h0A;
   localparam logic [4:0] A_ENERGY_LO = 5'h0B;
   localparam logic [4:0] A_ENERGY_HI = 5'h0C;
   localparam logic [4:0] A_PARAM = 5'h0D;
   localparam logic [4:0] A_USER = 5'h0E;
   localparam logic [4:0] A_LOGCNT = 5'h0F;
   // Control bit positions
   localparam int B_LR_EN = 0;
   localparam int B_OFF_EN = 1;
   localparam int B_IMM = 2;
   localparam int B_OPLOSS = 3;
   localparam int B_BASIS = 4;
   // Clear bits
   localparam int B_CLR_LOG = 0;
   localparam int B_CLR_ENERGY = 1;
   // Reset values
   localparam logic [4:0] CTRL_RST = 5'b1_1111;
   localparam logic [15:0] USER_INIT_CODE = 16'h1110;
   localparam logic [15:0] INIT_NONE = 16'h0000;
   localparam logic [1:0] UD_SAVE = 2'h1;
   localparam logic [1:0] UD_CLEAR = 2'h2;
   localparam logic [15:0] HOURS_MAX = 16'hFFFF;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   // ****************************************
   // Timing
   // ****************************************
   localparam longint CLK_HZ = 100_000_000;
   localparam longint STORE_DELAY_S = 5;
   localparam longint STORE_DELAY_CYC = STORE_DELAY_S * CLK_HZ;
   localparam longint HOUR_S = 3600;
   localparam longint HOUR_CYC = HOUR_S * CLK_HZ;

   typedef enum logic [2:0] {
      DKCL_RUN_IDLE = 3'b001,
      DKCL_RUN_ON = 3'b010,
      DKCL_RUN_OFFSTOP = 3'b100
   } dkcl_run_e;

   typedef struct packed {
      logic [4:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dkcl_bus_s;

   typedef struct packed {
      logic present;
      logic lr_key;
      logic off_key;
      logic auto_key;
      logic reset_key;
      logic up_key;
      logic down_key;
      logic enter_key;
   } dkcl_keys_s;

   typedef struct packed {
      logic [4:0] ctrl;
      logic [1:0] usrdef;
      logic user_valid;
      logic [15:0] init_sel;
      logic [7:0] cap;
      logic [15:0] param;
      logic [15:0] user_store;
      logic [15:0] elapsed;
      logic [15:0] fan;
      logic [1:0] clear;
      logic [31:0] energy;
      logic [7:0] log_count;
      logic [15:0] speed;
      logic [15:0] pend;
      logic [15:0] stored;
      logic key_held;
      logic [31:0] store_cnt;
      logic store_arm;
      logic [39:0] el_cnt;
      logic [39:0] fan_cnt;
      logic local_mode;
      logic op_fault;
      dkcl_run_e run;
      logic ext_run_prev;
      logic [2:0] edge_prev;
      logic defaults_reload;
      logic [31:0] rdata;
   } dkcl_state_s;
endpackage

// >>> dkcl_top.sv
// Top of the keypad configuration logic: settings, run gating, timers and logs
`timescale 1ns/1ns
// Overview of operation
// - Local/remote key toggles control source only when enabled and stopped.
// - OFF key stops the drive in auto when OFF-in-auto is enabled.
// - After OFF stop, restart needs run re-assert or Auto key.
// - OFF key ignored in auto when OFF-in-auto is disabled.
// - User-default save copies parameters and offers initialize choice 1110.
// - Initialize choice 1110 restores the last user-saved parameter values.
// - Choice 1110 refused until saved; clear erases save and withdraws it.
// - Capacity code 0 to FF; a change reloads dependent defaults.
// - Immediate mode applies increase/decrease changes at once.
// - Immediate mode stores speed 5 s after last key release.
// - Deferred mode holds old speed until enter is pressed.
// - Operator-loss fault latches on keypad removal until reset key.
// - With fault disabled, removal still stops motor but raises no fault.
// - Elapsed hours count power-on or running time by the basis bit.
// - Running means run command active or output voltage applied.
// - Elapsed-hours preset loads the counter; zero clears it.
// - Separate fan-hours counter loaded by its preset.
// - Fault-log clear erases trace and history logs.
// - Energy monitors persist; cleared only by energy-clear write.
module dkcl_top #(
   parameter longint STORE_DELAY = dkcl_pkg::STORE_DELAY_CYC,
   parameter longint HOUR_CYCLES = dkcl_pkg::HOUR_CYC,
   parameter logic [7:0] CAP_DEFAULT = 8'h00
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire dkcl_pkg::dkcl_bus_s bus,
   output logic [31:0] rdata,
   input wire dkcl_pkg::dkcl_keys_s keys_pin,
   input wire logic ext_run_pin,
   input wire logic output_voltage_on,
   input wire logic fan_running,
   input wire logic energy_pulse,
   input wire logic fault_log_event,
   output logic run_enable,
   output logic local_mode,
   output logic operator_fault,
   output logic [15:0] speed_command_monitor,
   output logic defaults_reload
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   localparam int KW = $bits(dkcl_pkg::dkcl_keys_s);
   localparam dkcl_pkg::dkcl_keys_s KEYS_IDLE = '{present: 1'b1, default: 1'b0};
   logic [KW:0] sync1_q;
   logic [KW:0] sync2_q;
   dkcl_pkg::dkcl_keys_s keys;
   logic ext_run;

   // Two stages; the first stage is read only by the second
   // Reset to an attached idle keypad, else a false removal fault follows reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync1_q <= {1'b0, KEYS_IDLE};
         sync2_q <= {1'b0, KEYS_IDLE};
      end else if (clk_en) begin
         sync1_q <= {ext_run_pin, keys_pin};
         sync2_q <= sync1_q;
      end
   end
   assign keys = sync2_q[KW-1:0];
   assign ext_run = sync2_q[KW];

   // ****************************************
   // State
   // ****************************************
   dkcl_pkg::dkcl_state_s s_q;
   dkcl_pkg::dkcl_state_s s_d;
   logic running;
   logic stopped;
   logic lr_rise;
   logic off_rise;
   logic auto_rise;
   logic ext_rise;
   logic updn;

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == dkcl_pkg::HOURS_MAX) ? v : v + 16'h0001;
   endfunction

   // Forty bits, since one hour of default clocks overflows a 32-bit count
   function automatic logic hour_tick(input logic [39:0] c);
      hour_tick = (longint'(c) >= HOUR_CYCLES - 1);
   endfunction

   // Running includes deceleration with voltage still applied
   assign running = (s_q.run == dkcl_pkg::DKCL_RUN_ON) || output_voltage_on;
   assign stopped = !running;
   assign lr_rise = keys.lr_key && !s_q.edge_prev[0];
   assign off_rise = keys.off_key && !s_q.edge_prev[1];
   assign auto_rise = keys.auto_key && !s_q.edge_prev[2];
   assign ext_rise = ext_run && !s_q.ext_run_prev;
   assign updn = keys.up_key || keys.down_key;

   // Next-state logic for all state
   always_comb begin
      s_d = s_q;
      s_d.edge_prev = {keys.auto_key, keys.off_key, keys.lr_key};
      s_d.ext_run_prev = ext_run;
      s_d.defaults_reload = 1'b0;
      s_d.rdata = dkcl_pkg::ZERO32;

      // Local/remote switch, only while stopped
      if (s_q.ctrl[dkcl_pkg::B_LR_EN] && lr_rise && stopped) begin
         s_d.local_mode = !s_q.local_mode;
      end

      // Operator-loss: latch fault or just stop
      if (!keys.present && s_q.ctrl[dkcl_pkg::B_OPLOSS]) begin
         s_d.op_fault = 1'b1;
      end else if (keys.present && keys.reset_key) begin
         s_d.op_fault = 1'b0;
      end

      // Run sequencing
      case (s_q.run)
         dkcl_pkg::DKCL_RUN_IDLE: begin
            if (ext_run && !s_q.op_fault && keys.present) begin
               s_d.run = dkcl_pkg::DKCL_RUN_ON;
            end
         end
         dkcl_pkg::DKCL_RUN_ON: begin
            if (!keys.present || s_q.op_fault) begin
               s_d.run = dkcl_pkg::DKCL_RUN_IDLE;
            end else if (off_rise && (s_q.local_mode || s_q.ctrl[dkcl_pkg::B_OFF_EN])) begin
               s_d.run = dkcl_pkg::DKCL_RUN_OFFSTOP;
            end else if (!ext_run) begin
               s_d.run = dkcl_pkg::DKCL_RUN_IDLE;
            end
         end
         dkcl_pkg::DKCL_RUN_OFFSTOP: begin
            // Held stop until the run line is cycled or Auto pressed
            if (ext_rise || (auto_rise && ext_run)) begin
               s_d.run = dkcl_pkg::DKCL_RUN_ON;
            end
         end
         default: s_d.run = dkcl_pkg::DKCL_RUN_IDLE;
      endcase

      // Keypad speed editing
      if (keys.up_key && s_q.pend != dkcl_pkg::HOURS_MAX) begin
         s_d.pend = s_q.pend + 16'h0001;
      end else if (keys.down_key && s_q.pend != dkcl_pkg::ZERO16) begin
         s_d.pend = s_q.pend - 16'h0001;
      end
      if (s_q.ctrl[dkcl_pkg::B_IMM]) begin
         s_d.speed = s_d.pend;
      end else if (keys.enter_key) begin
         s_d.speed = s_q.pend;
      end
      // Delayed store after the last key release
      s_d.key_held = updn;
      if (updn) begin
         s_d.store_arm = 1'b0;
         s_d.store_cnt = dkcl_pkg::ZERO32;
      end else if (s_q.key_held && s_q.ctrl[dkcl_pkg::B_IMM]) begin
         s_d.store_arm = 1'b1;
         s_d.store_cnt = dkcl_pkg::ZERO32;
      end else if (s_q.store_arm) begin
         if (longint'(s_q.store_cnt) >= STORE_DELAY - 1) begin
            s_d.stored = s_q.speed;
            s_d.store_arm = 1'b0;
         end else begin
            s_d.store_cnt = s_q.store_cnt + 32'h0000_0001;
         end
      end

      // Hour counters, saturating
      if (!s_q.ctrl[dkcl_pkg::B_BASIS] || running) begin
         if (hour_tick(s_q.el_cnt)) begin
            s_d.el_cnt = '0;
            s_d.elapsed = sat_inc(s_q.elapsed);
         end else begin
            s_d.el_cnt = s_q.el_cnt + 40'h00_0000_0001;
         end
      end
      if (fan_running) begin
         if (hour_tick(s_q.fan_cnt)) begin
            s_d.fan_cnt = '0;
            s_d.fan = sat_inc(s_q.fan);
         end else begin
            s_d.fan_cnt = s_q.fan_cnt + 40'h00_0000_0001;
         end
      end

      // Log and energy accumulation
      if (fault_log_event && s_q.log_count != 8'hFF) begin
         s_d.log_count = s_q.log_count + 8'h01;
      end
      if (energy_pulse) begin
         s_d.energy = s_q.energy + 32'h0000_0001;
      end

      // One-shot clears act then self-return
      if (s_q.clear[dkcl_pkg::B_CLR_LOG]) begin
         s_d.log_count = 8'h00;
         s_d.clear[dkcl_pkg::B_CLR_LOG] = 1'b0;
      end
      if (s_q.clear[dkcl_pkg::B_CLR_ENERGY]) begin
         s_d.energy = dkcl_pkg::ZERO32;
         s_d.clear[dkcl_pkg::B_CLR_ENERGY] = 1'b0;
      end

      // User-default store actions
      if (s_q.usrdef == dkcl_pkg::UD_SAVE) begin
         s_d.user_store = s_q.param;
         s_d.user_valid = 1'b1;
         s_d.usrdef = 2'h0;
      end else if (s_q.usrdef == dkcl_pkg::UD_CLEAR) begin
         s_d.user_store = dkcl_pkg::ZERO16;
         s_d.user_valid = 1'b0;
         s_d.usrdef = 2'h0;
      end
      if (s_q.init_sel == dkcl_pkg::USER_INIT_CODE) begin
         s_d.param = s_q.user_store;
         s_d.init_sel = dkcl_pkg::INIT_NONE;
      end

      // Register writes
      if (bus.wr) begin
         case (bus.addr)
            dkcl_pkg::A_CTRL: s_d.ctrl = bus.wdata[4:0];
            dkcl_pkg::A_USRDEF: s_d.usrdef = bus.wdata[1:0];
            dkcl_pkg::A_INIT: begin
               // Choice refused while nothing saved
               if (bus.wdata[15:0] != dkcl_pkg::USER_INIT_CODE || s_q.user_valid) begin
                  s_d.init_sel = bus.wdata[15:0];
               end
            end
            dkcl_pkg::A_CAP: begin
               s_d.cap = bus.wdata[7:0];
               s_d.defaults_reload = (bus.wdata[7:0] != s_q.cap);
            end
            dkcl_pkg::A_ELAPSED: begin
               s_d.elapsed = bus.wdata[15:0];
               s_d.el_cnt = '0;
            end
            dkcl_pkg::A_FAN: begin
               s_d.fan = bus.wdata[15:0];
               s_d.fan_cnt = '0;
            end
            dkcl_pkg::A_CLEAR: s_d.clear = bus.wdata[1:0];
            dkcl_pkg::A_PARAM: s_d.param = bus.wdata[15:0];
            default: ;
         endcase
      end

      // Register reads, data in the following cycle
      if (bus.rd) begin
         case (bus.addr)
            dkcl_pkg::A_CTRL: s_d.rdata = {27'h0, s_q.ctrl};
            dkcl_pkg::A_USRDEF: s_d.rdata = {30'h0, s_q.usrdef};
            dkcl_pkg::A_INIT: s_d.rdata = {16'h0, s_q.init_sel};
            dkcl_pkg::A_CAP: s_d.rdata = {24'h0, s_q.cap};
            dkcl_pkg::A_ELAPSED: s_d.rdata = {16'h0, s_q.elapsed};
            dkcl_pkg::A_FAN: s_d.rdata = {16'h0, s_q.fan};
            dkcl_pkg::A_CLEAR: s_d.rdata = {30'h0, s_q.clear};
            dkcl_pkg::A_STATUS: s_d.rdata = {25'h0, s_q.run, s_q.op_fault,
                                             s_q.local_mode, s_q.user_valid, running};
            dkcl_pkg::A_SPEED: s_d.rdata = {16'h0, s_q.speed};
            dkcl_pkg::A_PEND: s_d.rdata = {16'h0, s_q.pend};
            dkcl_pkg::A_STORED: s_d.rdata = {16'h0, s_q.stored};
            dkcl_pkg::A_ENERGY_LO: s_d.rdata = {16'h0, s_q.energy[15:0]};
            dkcl_pkg::A_ENERGY_HI: s_d.rdata = {16'h0, s_q.energy[31:16]};
            dkcl_pkg::A_PARAM: s_d.rdata = {16'h0, s_q.param};
            dkcl_pkg::A_USER: s_d.rdata = {16'h0, s_q.user_store};
            dkcl_pkg::A_LOGCNT: s_d.rdata = {24'h0, s_q.log_count};
            default: s_d.rdata = dkcl_pkg::ZERO32;
         endcase
      end
   end

   // Register all state; rst_n stands for a cold start, the only time the
   // retained energy and stored speed are zeroed besides their own clears
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl <= dkcl_pkg::CTRL_RST;
         s_q.cap <= CAP_DEFAULT;
         s_q.run <= dkcl_pkg::DKCL_RUN_IDLE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = s_q.rdata;
   assign run_enable = (s_q.run == dkcl_pkg::DKCL_RUN_ON) && keys.present;
   assign local_mode = s_q.local_mode;
   assign operator_fault = s_q.op_fault;
   assign speed_command_monitor = s_q.speed;
   assign defaults_reload = s_q.defaults_reload;
endmodule

// >>> dkcl_keypad_model.sv
// Partner model: detachable keypad and external run line
`timescale 1ns/1ns
module dkcl_keypad_model (
   input wire logic mclk,
   output dkcl_pkg::dkcl_keys_s keys_pin,
   output logic ext_run_pin
);
   // Keypad attached, no key down, run line off at power-up
   initial begin
      keys_pin = 8'h80;
      ext_run_pin = 1'b0;
   end
   // Hold one key n clocks; the trailing wait covers the two-flop sync
   task automatic press(input int idx, input int n);
      @(posedge mclk);
      keys_pin[idx] <= 1'b1;
      repeat (n) @(posedge mclk);
      keys_pin[idx] <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   // Plug or pull the keypad
   task automatic attach(input logic v);
      @(posedge mclk);
      keys_pin.present <= v;
      repeat (4) @(posedge mclk);
   endtask
   // External run command level
   task automatic set_ext(input logic v);
      @(posedge mclk);
      ext_run_pin <= v;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// >>> dkcl_top_asserts.sv
// Checker: port-level properties of the keypad configuration logic
`timescale 1ns/1ns
module dkcl_top_asserts #(
   parameter longint STORE_DELAY = 20,
   parameter longint HOUR_CYCLES = 10,
   parameter logic [7:0] CAP_DEFAULT = 8'h00
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire dkcl_pkg::dkcl_bus_s bus,
   input wire logic [31:0] rdata,
   input wire dkcl_pkg::dkcl_keys_s keys_pin,
   input wire logic ext_run_pin,
   input wire logic output_voltage_on,
   input wire logic fan_running,
   input wire logic energy_pulse,
   input wire logic fault_log_event,
   input wire logic run_enable,
   input wire logic local_mode,
   input wire logic operator_fault,
   input wire logic [15:0] speed_command_monitor,
   input wire logic defaults_reload
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Read data only in the cycle after a taken read
   a_rdata_idle: assert property ($past(clk_en) && !$past(bus.rd) |-> rdata == 32'h0000_0000)
      else $error("read data not zero outside read");
   // Reload only follows a capacity write, and lasts one cycle
   a_reload_cause: assert property (defaults_reload |->
      $past(bus.wr && bus.addr == dkcl_pkg::A_CAP)
      || $past(bus.wr && bus.addr == dkcl_pkg::A_CAP, 2))
      else $error("reload without capacity write");
   a_reload_pulse: assert property (defaults_reload |=> !defaults_reload)
      else $error("reload longer than one cycle");
   // Latched fault: set by removal, cleared only by the reset key
   a_fault_clear: assert property ($fell(operator_fault) |->
      $past(keys_pin.reset_key, 2) || $past(keys_pin.reset_key, 3)
      || $past(keys_pin.reset_key, 4))
      else $error("fault dropped without reset key");
   a_fault_cause: assert property ($rose(operator_fault) |->
      !$past(keys_pin.present, 2) || !$past(keys_pin.present, 3)
      || !$past(keys_pin.present, 4))
      else $error("fault raised with keypad present");
   a_fault_no_run: assert property (operator_fault |-> !run_enable)
      else $error("running while faulted");
   // Removal or a dropped run line stops the drive
   a_absent_stop: assert property (!keys_pin.present [*4] |=> !run_enable)
      else $error("running with keypad removed");
   a_ext_low_stop: assert property (!ext_run_pin [*4] |=> !run_enable)
      else $error("running without run command");
   // Control source never flips while running
   a_local_hold: assert property (run_enable |=> $stable(local_mode))
      else $error("control source changed while running");
endmodule
bind dkcl_top dkcl_top_asserts #(.STORE_DELAY(STORE_DELAY), .HOUR_CYCLES(HOUR_CYCLES),
   .CAP_DEFAULT(CAP_DEFAULT)) i_dkcl_top_asserts (.mclk(mclk), .rst_n(rst_n),
   .clk_en(clk_en), .bus(bus), .rdata(rdata), .keys_pin(keys_pin),
   .ext_run_pin(ext_run_pin), .output_voltage_on(output_voltage_on),
   .fan_running(fan_running), .energy_pulse(energy_pulse),
   .fault_log_event(fault_log_event), .run_enable(run_enable), .local_mode(local_mode),
   .operator_fault(operator_fault), .speed_command_monitor(speed_command_monitor),
   .defaults_reload(defaults_reload));

// >>> tb_top.sv
// Testbench: register, key and counter scenarios for the keypad configuration logic
`timescale 1ns/1ns
module tb_top;
   localparam longint SD = 20;
   localparam longint HC = 10;
   logic mclk, rst_n, clk_en, ext_run_pin, output_voltage_on, fan_running;
   logic energy_pulse, fault_log_event, run_enable, local_mode, operator_fault;
   logic defaults_reload;
   logic [15:0] speed_command_monitor;
   logic [31:0] rdata, v1, v2;
   dkcl_pkg::dkcl_bus_s bus;
   dkcl_pkg::dkcl_keys_s keys_pin;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_reload = 0;
   // ****************
   // Clock, design, keypad
   // ****************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   dkcl_top #(.STORE_DELAY(SD), .HOUR_CYCLES(HC)) i_dkcl_top (.mclk(mclk), .rst_n(rst_n),
      .clk_en(clk_en), .bus(bus), .rdata(rdata), .keys_pin(keys_pin),
      .ext_run_pin(ext_run_pin), .output_voltage_on(output_voltage_on),
      .fan_running(fan_running), .energy_pulse(energy_pulse),
      .fault_log_event(fault_log_event), .run_enable(run_enable), .local_mode(local_mode),
      .operator_fault(operator_fault), .speed_command_monitor(speed_command_monitor),
      .defaults_reload(defaults_reload));
   dkcl_keypad_model i_dkcl_keypad_model (.mclk(mclk), .keys_pin(keys_pin),
      .ext_run_pin(ext_run_pin));
   // Count reload pulses; pre-edge values, so no race with the design
   always @(posedge mclk) begin
      n_reload <= n_reload + int'(defaults_reload);
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         test_done();
      end
   end
   // ****************
   // Bus and compare tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask
   // Hour ticks over exactly 100 clocks between the two sampling edges
   task automatic hours(input logic [4:0] a, input logic [31:0] exp);
      rd(a, v1);
      repeat (98) @(posedge mclk);
      rd(a, v2);
      check(v2 - v1, exp);
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      bus = '0;
      output_voltage_on = 1'b0;
      fan_running = 1'b0;
      energy_pulse = 1'b0;
      fault_log_event = 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(dkcl_pkg::A_CTRL, 32'h0000_001F);
      rdc(dkcl_pkg::A_STATUS, 32'h0000_0010);
      rdc(5'h1F, 32'h0000_0000);
      // Restore refused before a save, honoured after, refused after erase
      wr(dkcl_pkg::A_PARAM, 32'h0000_00AA);
      wr(dkcl_pkg::A_INIT, 32'h0000_1110);
      rdc(dkcl_pkg::A_PARAM, 32'h0000_00AA);
      wr(dkcl_pkg::A_USRDEF, 32'h0000_0001);
      rdc(dkcl_pkg::A_STATUS, 32'h0000_0012);
      rdc(dkcl_pkg::A_USER, 32'h0000_00AA);
      rdc(dkcl_pkg::A_USRDEF, 32'h0000_0000);
      wr(dkcl_pkg::A_PARAM, 32'h0000_0055);
      wr(dkcl_pkg::A_INIT, 32'h0000_1110);
      repeat (2) @(posedge mclk);
      rdc(dkcl_pkg::A_PARAM, 32'h0000_00AA);
      rdc(dkcl_pkg::A_INIT, 32'h0000_0000);
      wr(dkcl_pkg::A_USRDEF, 32'h0000_0002);
      rdc(dkcl_pkg::A_STATUS, 32'h0000_0010);
      wr(dkcl_pkg::A_PARAM, 32'h0000_0033);
      wr(dkcl_pkg::A_INIT, 32'h0000_1110);
      rdc(dkcl_pkg::A_PARAM, 32'h0000_0033);
      // Capacity: reload on change only, both range ends
      wr(dkcl_pkg::A_CAP, 32'h0000_00FF);
      repeat (4) @(posedge mclk);
      check(32'(n_reload), 32'h0000_0001);
      wr(dkcl_pkg::A_CAP, 32'h0000_00FF);
      repeat (4) @(posedge mclk);
      check(32'(n_reload), 32'h0000_0001);
      rdc(dkcl_pkg::A_CAP, 32'h0000_00FF);
      wr(dkcl_pkg::A_CAP, 32'h0000_0000);
      repeat (4) @(posedge mclk);
      check(32'(n_reload), 32'h0000_0002);
      // Local/remote key, enabled and disabled
      i_dkcl_keypad_model.press(6, 2);
      check(32'(local_mode), 32'h0000_0001);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001E);
      i_dkcl_keypad_model.press(6, 2);
      check(32'(local_mode), 32'h0000_0001);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001F);
      i_dkcl_keypad_model.press(6, 2);
      check(32'(local_mode), 32'h0000_0000);
      // OFF key in auto and the two ways back to run
      i_dkcl_keypad_model.set_ext(1'b1);
      i_dkcl_keypad_model.press(6, 2);
      check(32'(local_mode), 32'h0000_0000);
      i_dkcl_keypad_model.press(5, 2);
      check(32'(run_enable), 32'h0000_0000);
      i_dkcl_keypad_model.press(4, 2);
      check(32'(run_enable), 32'h0000_0001);
      i_dkcl_keypad_model.press(5, 2);
      i_dkcl_keypad_model.set_ext(1'b0);
      i_dkcl_keypad_model.set_ext(1'b1);
      check(32'(run_enable), 32'h0000_0001);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001D);
      i_dkcl_keypad_model.press(5, 2);
      check(32'(run_enable), 32'h0000_0001);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001F);
      // Hour counters by basis, run state, voltage and fan
      hours(dkcl_pkg::A_ELAPSED, 32'(100 / HC));
      hours(dkcl_pkg::A_FAN, 32'h0000_0000);
      fan_running <= 1'b1;
      hours(dkcl_pkg::A_FAN, 32'(100 / HC));
      fan_running <= 1'b0;
      i_dkcl_keypad_model.set_ext(1'b0);
      hours(dkcl_pkg::A_ELAPSED, 32'h0000_0000);
      output_voltage_on <= 1'b1;
      hours(dkcl_pkg::A_ELAPSED, 32'(100 / HC));
      output_voltage_on <= 1'b0;
      wr(dkcl_pkg::A_CTRL, 32'h0000_000F);
      hours(dkcl_pkg::A_ELAPSED, 32'(100 / HC));
      wr(dkcl_pkg::A_CTRL, 32'h0000_001F);
      wr(dkcl_pkg::A_ELAPSED, 32'h0000_1234);
      rdc(dkcl_pkg::A_ELAPSED, 32'h0000_1234);
      wr(dkcl_pkg::A_ELAPSED, 32'h0000_0000);
      rdc(dkcl_pkg::A_ELAPSED, 32'h0000_0000);
      wr(dkcl_pkg::A_ELAPSED, 32'h0000_FFFE);
      wr(dkcl_pkg::A_FAN, 32'h0000_FFFE);
      fan_running <= 1'b1;
      output_voltage_on <= 1'b1;
      repeat (30) @(posedge mclk);
      rdc(dkcl_pkg::A_FAN, 32'h0000_FFFF);
      rdc(dkcl_pkg::A_ELAPSED, 32'h0000_FFFF);
      fan_running <= 1'b0;
      output_voltage_on <= 1'b0;
      // Logs and energy: separate clears, self-clearing setting
      wr(dkcl_pkg::A_CLEAR, 32'h0000_0003);
      @(posedge mclk);
      fault_log_event <= 1'b1;
      energy_pulse <= 1'b1;
      repeat (3) @(posedge mclk);
      fault_log_event <= 1'b0;
      energy_pulse <= 1'b0;
      rdc(dkcl_pkg::A_LOGCNT, 32'h0000_0003);
      wr(dkcl_pkg::A_CLEAR, 32'h0000_0001);
      rdc(dkcl_pkg::A_LOGCNT, 32'h0000_0000);
      rdc(dkcl_pkg::A_ENERGY_LO, 32'h0000_0003);
      rdc(dkcl_pkg::A_ENERGY_HI, 32'h0000_0000);
      rdc(dkcl_pkg::A_CLEAR, 32'h0000_0000);
      wr(dkcl_pkg::A_CLEAR, 32'h0000_0002);
      rdc(dkcl_pkg::A_ENERGY_LO, 32'h0000_0000);
      // Keypad speed: immediate with delayed store, then deferred
      i_dkcl_keypad_model.press(2, 10);
      check(32'(speed_command_monitor), 32'h0000_000A);
      rdc(dkcl_pkg::A_STORED, 32'h0000_0000);
      repeat (SD) @(posedge mclk);
      rdc(dkcl_pkg::A_STORED, 32'h0000_000A);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001B);
      i_dkcl_keypad_model.press(1, 4);
      check(32'(speed_command_monitor), 32'h0000_000A);
      rdc(dkcl_pkg::A_PEND, 32'h0000_0006);
      i_dkcl_keypad_model.press(0, 1);
      check(32'(speed_command_monitor), 32'h0000_0006);
      wr(dkcl_pkg::A_CTRL, 32'h0000_001F);
      // Clock enable low freezes the synchronisers: a held key is lost
      clk_en <= 1'b0;
      i_dkcl_keypad_model.press(2, 3);
      clk_en <= 1'b1;
      check(32'(speed_command_monitor), 32'h0000_0006);
      // Keypad removal with the fault on, then off
      i_dkcl_keypad_model.set_ext(1'b1);
      i_dkcl_keypad_model.attach(1'b0);
      check(32'(operator_fault), 32'h0000_0001);
      i_dkcl_keypad_model.attach(1'b1);
      repeat (10) @(posedge mclk);
      check(32'(operator_fault), 32'h0000_0001);
      i_dkcl_keypad_model.press(3, 2);
      check(32'(operator_fault), 32'h0000_0000);
      wr(dkcl_pkg::A_CTRL, 32'h0000_0017);
      i_dkcl_keypad_model.attach(1'b0);
      check(32'(operator_fault), 32'h0000_0000);
      check(32'(run_enable), 32'h0000_0000);
      i_dkcl_keypad_model.attach(1'b1);
      test_done();
   end
endmodule
